// [design/qtc_pkg.sv]
// ============================================================
// Shared constants for the quadrant turns counter
// ============================================================
package qtc_pkg;
  localparam int ANGLE_W = 16;
  localparam int COUNT_W = 11;
  localparam int REG_W = 16;
  localparam int ADDR_W = 6;
  localparam int CHANNELS = 2;

  // Register offsets.
  localparam logic [ADDR_W-1:0] REG_RESET_CONTROL = 6'h0f;
  localparam logic [ADDR_W-1:0] REG_PRIMARY_TURNS_LIVE = 6'h15;
  localparam logic [ADDR_W-1:0] REG_PRIMARY_TURNS_LATCHED = 6'h1b;
  localparam logic [ADDR_W-1:0] REG_SECONDARY_TURNS_LIVE = 6'h1c;
  localparam logic [ADDR_W-1:0] REG_SECONDARY_TURNS_LATCHED = 6'h1d;
  localparam logic [REG_W-1:0] RESET_CONTROL_RESET = 16'h0000;

  // Field positions.
  localparam int TURNS_FIELD_MSB = 10;
  localparam int SATURATION_FLAG_BIT = 12;
  localparam int CONTROL_COUNTER_RESET_BIT = 0;

  // Angle scale: a full turn spans 2^16 codes.
  localparam logic [ANGLE_W-1:0] QUADRANT_SPAN = 16'h4000;
  localparam logic [ANGLE_W-1:0] HYSTERESIS_SPAN = 16'h0400;
  localparam logic signed [COUNT_W-1:0] COUNT_MAX = 11'sh3ff;
  localparam logic signed [COUNT_W-1:0] COUNT_MIN = 11'sh400;

  // Sleep period timing.
  localparam int CLK_HZ = 20_000_000;
  localparam int SLEEP_TIME_US = 1700;
  localparam int SLEEP_CYCLES = SLEEP_TIME_US * (CLK_HZ / 1_000_000);

  typedef enum logic [1:0] {
    QTC_RUN,
    QTC_SLEEP,
    QTC_WAKE,
    QTC_TRANSPORT
  } qtc_power_t;
endpackage

// [design/qtc_turns_counter.sv]
`timescale 1ns/100ps
// Overview of operation
// [RULE1] One quadrant turns counter per channel, following that channel's angle.
// [RULE2] Count changes only after the angle passes a boundary by 5.625 degrees.
// [RULE3] A per-channel configuration bit switches that channel's boundary hysteresis off.
// [RULE4] Each count reads as bits 10..0 of a live and a latched register.
// [RULE5] Counters saturate at +1023 and -1024 and never wrap.
// [RULE6] Saturation sets a sticky flag at bit 12, cleared only by counter reset.
// [RULE7] In low power the wake sample alone updates the count.
// [RULE8] Direction comes from the signed sample difference; 180 degrees is ambiguous.
// [RULE9] Any reset event, including a control register write, resets both counters.
// [RULE10] After reset the count starts at zero or the first sample's quadrant.
// [RULE11] Later steps are counted relative to that initial point.
// [RULE12] Software should program both initialisation selects alike.
// [RULE13] Transport enable plus low-power entry gives transport mode, no counting.
// [RULE14] Any serial input high leaves transport mode.
// [RULE15] Transport mode is never entered while transport enable is zero.
// [RULE16] Shadow transport bit clears on transport exit when the stored bit is zero.
// [RULE17] Low power is entered only with all serial inputs low and not disabled.
// [RULE18] The sleep state times the period, then wakes to take a sample.
// [RULE19] Any serial input high leaves low-power mode.
// [RULE20] Turns counts are two's-complement signed values.
// [RULE21] Quadrant 0 is 0 to below 90 degrees, then 1, 2, 3.
module qtc_turns_counter #(
  parameter int SLEEP_CYCLES = qtc_pkg::SLEEP_CYCLES
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [qtc_pkg::ANGLE_W-1:0] primary_angle_i,
  input wire logic [qtc_pkg::ANGLE_W-1:0] secondary_angle_i,
  input wire logic angle_valid_i,
  input wire logic primary_boundary_hysteresis_off_i,
  input wire logic secondary_boundary_hysteresis_off_i,
  input wire logic primary_count_init_select_i,
  input wire logic secondary_count_init_select_i,
  input wire logic low_power_disable_i,
  input wire logic transport_enable_stored_i,
  input wire logic transport_shadow_load_i,
  input wire logic transport_shadow_value_i,
  input wire logic spi_sclk_i,
  input wire logic spi_mosi_i,
  input wire logic spi_csn_i,
  input wire logic count_latch_i,
  input wire logic [qtc_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  input wire logic [qtc_pkg::REG_W-1:0] reg_wdata_i,
  output logic [qtc_pkg::REG_W-1:0] reg_rdata_o,
  output logic low_power_mode_o,
  output logic transport_mode_o,
  output logic sleep_osc_enable_o,
  output logic sample_request_o,
  output logic transport_enable_o
);
  import qtc_pkg::*;

  localparam int SLEEP_W = $clog2(SLEEP_CYCLES + 1);
  localparam logic [SLEEP_W-1:0] SLEEP_RELOAD = SLEEP_W'(SLEEP_CYCLES - 1);

  // ============================================================
  // Register port decode
  // ============================================================
  logic [REG_W-1:0] reset_control;
  logic [REG_W-1:0] next_reset_control;
  logic [REG_W-1:0] next_reg_rdata;
  logic counter_clear;
  logic [REG_W-1:0] live_word [CHANNELS];
  logic [REG_W-1:0] latched_word [CHANNELS];

  always_comb
  begin
    next_reset_control = reset_control;
    next_reg_rdata = reg_rdata_o;
    counter_clear = 1'b0;
    if (reg_write_i && reg_addr_i == REG_RESET_CONTROL)
    begin
      // The reset bit acts as a command and never reads back as set.
      next_reset_control = reg_wdata_i;
      next_reset_control[CONTROL_COUNTER_RESET_BIT] = 1'b0;
      // [RULE9] control write reset
      counter_clear = reg_wdata_i[CONTROL_COUNTER_RESET_BIT];
    end
    if (reg_read_i)
    begin
      // [RULE4] live and latched readback
      case (reg_addr_i)
        REG_RESET_CONTROL: next_reg_rdata = reset_control;
        REG_PRIMARY_TURNS_LIVE: next_reg_rdata = live_word[0];
        REG_PRIMARY_TURNS_LATCHED: next_reg_rdata = latched_word[0];
        REG_SECONDARY_TURNS_LIVE: next_reg_rdata = live_word[1];
        REG_SECONDARY_TURNS_LATCHED: next_reg_rdata = latched_word[1];
        default: next_reg_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      reset_control <= RESET_CONTROL_RESET;
      reg_rdata_o <= '0;
    end
    else
    begin
      reset_control <= next_reset_control;
      reg_rdata_o <= next_reg_rdata;
    end
  end

  // ============================================================
  // Power state control
  // ============================================================
  qtc_power_t state;
  qtc_power_t next_state;
  logic [SLEEP_W-1:0] sleep_count;
  logic [SLEEP_W-1:0] next_sleep_count;
  logic next_transport_enable;
  logic pins_low;
  logic sample_take;

  always_comb
  begin
    next_state = state;
    next_sleep_count = sleep_count;
    next_transport_enable = transport_enable_o;
    pins_low = !spi_sclk_i && !spi_mosi_i && !spi_csn_i;
    case (state)
      QTC_RUN:
      begin
        // [RULE17] entry condition
        if (pins_low && !low_power_disable_i)
        begin
          // [RULE13] transport instead of sleep
          // [RULE15] only with enable set
          if (transport_enable_o)
            next_state = QTC_TRANSPORT;
          else
            next_state = QTC_SLEEP;
          next_sleep_count = SLEEP_RELOAD;
        end
      end
      QTC_SLEEP:
      begin
        // [RULE19] wake on serial activity
        if (!pins_low)
          next_state = QTC_RUN;
        // [RULE18] sleep period expiry
        else if (sleep_count == '0)
          next_state = QTC_WAKE;
        else
          next_sleep_count = sleep_count - 1'b1;
      end
      QTC_WAKE:
      begin
        if (!pins_low)
          next_state = QTC_RUN;
        else if (angle_valid_i)
        begin
          next_state = QTC_SLEEP;
          next_sleep_count = SLEEP_RELOAD;
        end
      end
      QTC_TRANSPORT:
      begin
        // [RULE14] serial line high exits
        if (!pins_low)
        begin
          next_state = QTC_RUN;
          // [RULE16] volatile enable clears
          if (!transport_enable_stored_i)
            next_transport_enable = 1'b0;
        end
      end
      default: next_state = QTC_RUN;
    endcase
    // A shadow write in the exit cycle wins over the automatic clear.
    if (transport_shadow_load_i)
      next_transport_enable = transport_shadow_value_i;
  end

  // [RULE7] only run-mode and wake samples count
  assign sample_take = angle_valid_i && (state == QTC_RUN || state == QTC_WAKE);

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state <= QTC_RUN;
      sleep_count <= '0;
      transport_enable_o <= 1'b0;
      low_power_mode_o <= 1'b0;
      transport_mode_o <= 1'b0;
      sleep_osc_enable_o <= 1'b0;
      sample_request_o <= 1'b0;
    end
    else
    begin
      state <= next_state;
      sleep_count <= next_sleep_count;
      transport_enable_o <= next_transport_enable;
      low_power_mode_o <= (next_state != QTC_RUN);
      transport_mode_o <= (next_state == QTC_TRANSPORT);
      // [RULE13] oscillator stopped in transport
      sleep_osc_enable_o <= (next_state == QTC_SLEEP || next_state == QTC_WAKE);
      sample_request_o <= (next_state == QTC_WAKE);
    end
  end

  // ============================================================
  // Per-channel turns counters
  // ============================================================
  logic [ANGLE_W-1:0] angle [CHANNELS];
  logic [CHANNELS-1:0] hyst_off;
  logic [CHANNELS-1:0] init_select;

  assign angle[0] = primary_angle_i;
  assign angle[1] = secondary_angle_i;
  // [RULE3] per-channel hysteresis disable
  assign hyst_off = {secondary_boundary_hysteresis_off_i, primary_boundary_hysteresis_off_i};
  assign init_select = {secondary_count_init_select_i, primary_count_init_select_i};

  for (genvar ch = 0; ch < CHANNELS; ch++)
  begin : g_chan
    // [RULE20] signed count storage
    logic signed [COUNT_W-1:0] count;
    logic signed [COUNT_W-1:0] next_count;
    logic signed [COUNT_W-1:0] held_count;
    logic signed [COUNT_W-1:0] next_held_count;
    logic [1:0] quad;
    logic [1:0] next_quad;
    logic flag;
    logic next_flag;
    logic held_flag;
    logic next_held_flag;
    logic armed;
    logic next_armed;
    logic [ANGLE_W-1:0] hyst;
    logic signed [ANGLE_W-1:0] offset;
    logic signed [ANGLE_W-1:0] up_limit;
    logic signed [ANGLE_W-1:0] down_limit;

    always_comb
    begin
      next_count = count;
      next_quad = quad;
      next_flag = flag;
      next_armed = armed;
      // [RULE2] boundary hysteresis margin
      hyst = hyst_off[ch] ? '0 : HYSTERESIS_SPAN;
      up_limit = $signed(QUADRANT_SPAN + hyst);
      down_limit = -$signed(hyst);
      // [RULE8] signed distance from reference
      offset = $signed(angle[ch] - {quad, {(ANGLE_W - 2){1'b0}}});
      if (counter_clear)
      begin
        next_count = '0;
        next_quad = '0;
        next_flag = 1'b0;
        next_armed = 1'b0;
      end
      else if (sample_take)
      begin
        if (!armed)
        begin
          next_armed = 1'b1;
          // [RULE21] quadrant from top bits
          next_quad = angle[ch][ANGLE_W-1:ANGLE_W-2];
          // [RULE10] zero or quadrant start
          next_count = init_select[ch] ? $signed({{(COUNT_W - 2){1'b0}}, angle[ch][ANGLE_W-1:ANGLE_W-2]}) : '0;
        end
        // [RULE1] quadrant step tracking
        // [RULE11] relative to initial point
        else if (offset >= up_limit)
        begin
          next_quad = quad + 2'h1;
          // [RULE5] saturate at upper limit
          if (count == COUNT_MAX)
            next_flag = 1'b1;
          else
            next_count = count + 11'sh001;
        end
        else if (offset < down_limit)
        begin
          next_quad = quad - 2'h1;
          if (count == COUNT_MIN)
            next_flag = 1'b1;
          else
            next_count = count - 11'sh001;
        end
      end
      next_held_count = count_latch_i ? count : held_count;
      // [RULE6] sticky flag in both copies
      next_held_flag = (held_flag || next_flag || (count_latch_i && flag)) && !counter_clear;
      if (counter_clear)
        next_held_count = '0;
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
      if (!resetn_i)
      begin
        count <= '0;
        held_count <= '0;
        quad <= '0;
        flag <= 1'b0;
        held_flag <= 1'b0;
        armed <= 1'b0;
      end
      else
      begin
        count <= next_count;
        held_count <= next_held_count;
        quad <= next_quad;
        flag <= next_flag;
        held_flag <= next_held_flag;
        armed <= next_armed;
      end
    end

    // [RULE4] eleven-bit field, flag at bit 12
    always_comb
    begin
      live_word[ch] = '0;
      live_word[ch][TURNS_FIELD_MSB:0] = count;
      live_word[ch][SATURATION_FLAG_BIT] = flag;
      latched_word[ch] = '0;
      latched_word[ch][TURNS_FIELD_MSB:0] = held_count;
      latched_word[ch][SATURATION_FLAG_BIT] = held_flag;
    end
  end

endmodule

// [test/qtc_turns_checker.sv]
`timescale 1ns/100ps
// ==========
// Checker
module qtc_turns_checker #(
  parameter int SLEEP_CYCLES = 8
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic angle_valid_i,
  input wire logic low_power_disable_i,
  input wire logic transport_enable_stored_i,
  input wire logic transport_shadow_load_i,
  input wire logic spi_sclk_i,
  input wire logic spi_mosi_i,
  input wire logic spi_csn_i,
  input wire logic [qtc_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  input wire logic [qtc_pkg::REG_W-1:0] reg_wdata_i,
  input wire logic [qtc_pkg::REG_W-1:0] reg_rdata_o,
  input wire logic low_power_mode_o,
  input wire logic transport_mode_o,
  input wire logic sleep_osc_enable_o,
  input wire logic sample_request_o,
  input wire logic transport_enable_o
);
  import qtc_pkg::*;
  logic pins_low;
  logic [15:0] sleep_count;
  logic [15:0] next_sleep_count;
  assign pins_low = !(spi_sclk_i || spi_mosi_i || spi_csn_i);
  always_comb
  begin
    next_sleep_count = 16'h0000;
    if (sleep_osc_enable_o && !sample_request_o)
      next_sleep_count = sleep_count + 16'h0001;
  end
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      sleep_count <= 16'h0000;
    else
      sleep_count <= next_sleep_count;
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  sequence s_clear;
    reg_write_i && reg_addr_i == REG_RESET_CONTROL && reg_wdata_i[0] && !angle_valid_i;
  endsequence
  sequence s_read_live;
    reg_read_i && reg_addr_i == REG_PRIMARY_TURNS_LIVE && !angle_valid_i;
  endsequence
  a_power_entry_ok: assert property (
    !low_power_mode_o && pins_low && !low_power_disable_i |=> low_power_mode_o)
    else $error("low power not entered");
  a_power_stays_off: assert property (
    !low_power_mode_o && (!pins_low || low_power_disable_i) |=> !low_power_mode_o)
    else $error("low power entered wrongly");
  a_power_pin_exit: assert property (
    low_power_mode_o && !pins_low |=> !low_power_mode_o && !transport_mode_o)
    else $error("low power not left");
  a_transport_needs_en: assert property (
    $rose(transport_mode_o) |-> $past(transport_enable_o) && !sleep_osc_enable_o)
    else $error("transport entered without enable");
  a_shadow_bit_clear: assert property (
    transport_mode_o && !pins_low && !transport_enable_stored_i && !transport_shadow_load_i
    |=> !transport_enable_o)
    else $error("shadow bit kept");
  a_sleep_period_len: assert property (
    $rose(sample_request_o) |-> sleep_count == SLEEP_CYCLES)
    else $error("sleep period length wrong");
  a_wake_sample_back: assert property (
    sample_request_o && angle_valid_i && pins_low |=> !sample_request_o && sleep_osc_enable_o)
    else $error("wake not returned to sleep");
  a_clear_reads_zero: assert property (
    s_clear ##1 (!angle_valid_i && !reg_read_i) ##1 s_read_live |=> reg_rdata_o == 16'h0000)
    else $error("count not cleared");
endmodule
bind qtc_turns_counter qtc_turns_checker #(.SLEEP_CYCLES(SLEEP_CYCLES)) i_chk (.*);

// [test/qtc_angle_source.sv]
`timescale 1ns/100ps
// ==========
// Angle source
module qtc_angle_source #(
  parameter int DELAY = 2
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic sample_request_i,
  input wire logic send_i,
  output logic angle_valid_o
);
  logic [3:0] wait_count;
  logic [3:0] next_wait_count;
  always_comb
  begin
    next_wait_count = sample_request_i ? wait_count + 4'h1 : 4'h0;
  end
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      wait_count <= 4'h0;
    else
      wait_count <= next_wait_count;
  end
  assign angle_valid_o = send_i || (sample_request_i && wait_count == 4'(DELAY));
endmodule

// [test/tb_top.sv]
`timescale 1ns/100ps
// ==========
// Testbench
module tb_top;
  import qtc_pkg::*;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [15:0] primary_angle_i = 16'h0000;
  logic [15:0] secondary_angle_i = 16'h0000;
  logic angle_valid_i;
  logic send = 1'b0;
  logic primary_boundary_hysteresis_off_i = 1'b0;
  logic secondary_boundary_hysteresis_off_i = 1'b1;
  logic primary_count_init_select_i = 1'b1;
  logic secondary_count_init_select_i = 1'b1;
  logic low_power_disable_i = 1'b0;
  logic transport_enable_stored_i = 1'b0;
  logic transport_shadow_load_i = 1'b0;
  logic transport_shadow_value_i = 1'b0;
  logic spi_sclk_i = 1'b0;
  logic spi_mosi_i = 1'b0;
  logic spi_csn_i = 1'b1;
  logic count_latch_i = 1'b0;
  logic [5:0] reg_addr_i = 6'h00;
  logic reg_write_i = 1'b0;
  logic reg_read_i = 1'b0;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic [15:0] reg_rdata_o;
  logic low_power_mode_o, transport_mode_o, sleep_osc_enable_o, sample_request_o, transport_enable_o;
  int failures = 0;
  int check_count = 0;
  qtc_turns_counter #(.SLEEP_CYCLES(8)) i_dut (.*);
  qtc_angle_source i_src (.clk_i(clk_i), .resetn_i(resetn_i), .sample_request_i(sample_request_o),
    .send_i(send), .angle_valid_o(angle_valid_i));
  always #25 clk_i = ~clk_i;
  task print_verdict;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task rd(input logic [5:0] a, input logic [15:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge clk_i);
    reg_read_i <= 1'b0;
    #1;
    chk(reg_rdata_o, e);
  endtask
  task wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge clk_i);
    reg_write_i <= 1'b0;
  endtask
  task smp(input logic [15:0] p, input logic [15:0] s);
    @(posedge clk_i);
    primary_angle_i <= p;
    secondary_angle_i <= s;
    send <= 1'b1;
    @(posedge clk_i);
    send <= 1'b0;
  endtask
  task step(input logic [15:0] p, input logic [15:0] s, input logic [15:0] ep, input logic [15:0] es);
    smp(p, s);
    rd(6'h15, ep);
    rd(6'h1c, es);
  endtask
  task sweep(input int n, input logic [15:0] d);
    repeat (n) smp(primary_angle_i + d, secondary_angle_i + d);
  endtask
  task wreq(input logic lvl);
    int i;
    for (i = 0; i < 40 && sample_request_o !== lvl; i++)
    begin
      @(posedge clk_i);
      #1;
    end
    if (i == 40)
    begin
      $display("wrong value at %0t: no wake change", $time);
      failures++;
      print_verdict();
    end
  endtask
  task t_regs;
    rd(6'h15, 16'h0000);
    rd(6'h1d, 16'h0000);
    rd(6'h3f, 16'h0000);
    wr(6'h15, 16'h0123);
    rd(6'h15, 16'h0000);
    wr(6'h0f, 16'h00f0);
    rd(6'h0f, 16'h00f0);
  endtask
  task t_count;
    step(16'h8000, 16'hc100, 16'h0002, 16'h0003);
    step(16'hc3ff, 16'h0000, 16'h0002, 16'h0004);
    step(16'hc400, 16'h0000, 16'h0003, 16'h0004);
    step(16'hbc00, 16'h0000, 16'h0003, 16'h0004);
    step(16'hbbff, 16'h0000, 16'h0002, 16'h0004);
  endtask
  task t_saturate;
    sweep(1030, 16'hc000);
    rd(6'h15, 16'h1400);
    rd(6'h1c, 16'h1400);
    @(posedge clk_i);
    count_latch_i <= 1'b1;
    @(posedge clk_i);
    count_latch_i <= 1'b0;
    rd(6'h1b, 16'h1400);
    rd(6'h1d, 16'h1400);
    sweep(2050, 16'h4000);
    rd(6'h15, 16'h13ff);
    rd(6'h1c, 16'h13ff);
    wr(6'h0f, 16'h0001);
    rd(6'h15, 16'h0000);
    rd(6'h1b, 16'h0000);
    @(posedge clk_i);
    primary_count_init_select_i <= 1'b0;
    secondary_count_init_select_i <= 1'b0;
    step(16'h4000, 16'h8000, 16'h0000, 16'h0000);
  endtask
  task t_power;
    @(posedge clk_i);
    low_power_disable_i <= 1'b1;
    spi_csn_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    low_power_disable_i <= 1'b0;
    primary_angle_i <= 16'h8400;
    #1;
    chk(low_power_mode_o, 1'b0);
    @(posedge clk_i);
    #1;
    chk({sleep_osc_enable_o, transport_mode_o, low_power_mode_o}, 3'b101);
    wreq(1'b1);
    wreq(1'b0);
    @(posedge clk_i);
    spi_csn_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    chk(low_power_mode_o, 1'b0);
    rd(6'h15, 16'h0001);
    @(posedge clk_i);
    transport_shadow_value_i <= 1'b1;
    transport_shadow_load_i <= 1'b1;
    @(posedge clk_i);
    transport_shadow_load_i <= 1'b0;
    spi_csn_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    #1;
    chk({sleep_osc_enable_o, sample_request_o, transport_mode_o, transport_enable_o}, 4'h3);
    @(posedge clk_i);
    spi_mosi_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    chk({low_power_mode_o, transport_enable_o}, 2'b00);
    // With the stored bit set, the shadow enable must survive a transport exit.
    @(posedge clk_i);
    transport_enable_stored_i <= 1'b1;
    transport_shadow_load_i <= 1'b1;
    @(posedge clk_i);
    transport_shadow_load_i <= 1'b0;
    spi_mosi_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    chk(transport_mode_o, 1'b1);
    @(posedge clk_i);
    spi_sclk_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    chk({low_power_mode_o, transport_enable_o}, 2'b01);
    // A hardware reset in mid-run must clear the count and the shadow enable.
    @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    #1;
    chk(transport_enable_o, 1'b0);
    rd(6'h15, 16'h0000);
  endtask
  initial
  begin
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_regs;
    t_count;
    t_saturate;
    t_power;
    print_verdict();
  end
endmodule
